/* File: logic/dual_mode_compare_timer.sv */
// Compare timer: one 16-bit or two 8-bit up-counters with compare, flags and toggle pins.
// Assumes an 8-bit register port with read data one cycle after the read strobe.
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
`include "dual_timer_map.svh"
module dual_mode_compare_timer
(
    input wire logic core_clk, // Core clock, 100 MHz.
    input wire logic nrst, // Synchronous reset, active low.
    input wire logic [15:0] addr, // Register address.
    input wire logic [7:0] wdata, // Write data.
    input wire logic wr, // Write strobe.
    input wire logic rd, // Read strobe.
    output logic [7:0] rdata, // Read data, one cycle after rd.
    input wire logic event_in, // External event pin.
    input wire logic event_fall, // Event edge select, high for falling.
    input wire logic watch_clk, // Watch clock level.
    input wire logic low_power, // Chip is in watch, subactive or subsleep.
    input wire logic irq_en_hi, // Upper interrupt enable.
    input wire logic irq_en_lo, // Lower interrupt enable.
    input wire logic irq_ack_hi, // Pulse clears the upper request.
    input wire logic irq_ack_lo, // Pulse clears the lower request.
    output logic irq_req_hi, // Upper interrupt request flag.
    output logic irq_req_lo, // Lower interrupt request flag.
    output logic cpu_irq_hi, // Upper interrupt to the CPU.
    output logic cpu_irq_lo, // Lower interrupt to the CPU.
    output logic toggle_out_hi, // Upper toggle pin.
    output logic toggle_out_lo // Lower toggle pin.
);
    dual_timer_pkg::byte_t cnt_hi_ff, cnt_lo_ff, cmp_hi_ff, cmp_lo_ff;
    dual_timer_pkg::byte_t ctrl_ff, stop_ff, buf_ff;
    dual_timer_pkg::byte_t nxt_cnt_hi, nxt_cnt_lo, nxt_rdata, flag_rd;
    logic [3:0] flags_ff; // Wrap hi, hit hi, wrap lo, hit lo.
    logic [3:0] armed_ff; // Same order: flag was read as one.
    logic [3:0] cfg_ff; // Wrap ie hi, clear hi, wrap ie lo, clear lo.
    logic [3:0] set_ev, clr_ok;
    logic wide, tick_lo, tick_hi, hit_w, hit_h, hit_l, standby;
    logic run_main, run_watch;
    logic w_ctrl, w_flag, w_cnt_hi, w_cnt_lo, w_cmp_hi, w_cmp_lo, w_stop;
    logic r_flag, r_cnt_hi, r_cmp_hi;
    logic [15:0] pair, cmp_pair;

    tick_if tk ();

    ////////////////////////////////////////////////////////////////////////////////
    // Picks the tick of a source code; the event source only when allowed.
    function automatic logic sel_tick(input logic [2:0] src, input logic evt_ok,
                                      input logic t32, input logic t16, input logic t4,
                                      input logic tw, input logic te);
        logic t;
        t = 1'b0;
        case (dual_timer_pkg::clk_src_e'(src))
            dual_timer_pkg::SRC_EVENT: t = evt_ok && te;
            dual_timer_pkg::SRC_DIV32: t = t32;
            dual_timer_pkg::SRC_DIV16: t = t16;
            dual_timer_pkg::SRC_DIV4: t = t4;
            dual_timer_pkg::SRC_WDIV4: t = tw;
            default: t = 1'b0;
        endcase
        return t;
    endfunction

    // Address decode helper for strobed accesses.
    function automatic logic hit_addr(input logic strobe, input logic [15:0] a,
                                      input logic [15:0] target);
        return strobe && (a == target);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Module standby halts all ticks; low power keeps only the watch-derived tick.
    assign standby = !stop_ff[`TM_STOP_BIT];
    assign run_main = !standby && !low_power;
    assign run_watch = !standby;

    tick_prescaler u_pre
    (
        .core_clk(core_clk),
        .nrst(nrst),
        .run_main(run_main),
        .run_watch(run_watch),
        .watch_clk(watch_clk),
        .event_in(event_in),
        .event_fall(event_fall),
        .tk(tk.src)
    );

    // Tick selection for both halves; the upper half never sees the event input.
    assign wide = !ctrl_ff[`TM_WIDTH_SEL];
    assign tick_lo = sel_tick(ctrl_ff[`TM_SRC_LO_MSB:`TM_SRC_LO_LSB], 1'b1, tk.div32,
                              tk.div16, tk.div4, tk.wdiv4, tk.evt);
    assign tick_hi = sel_tick(ctrl_ff[`TM_SRC_HI_MSB:`TM_SRC_HI_LSB], 1'b0, tk.div32,
                              tk.div16, tk.div4, tk.wdiv4, tk.evt);

    // Register strobes.
    assign w_ctrl = hit_addr(wr, addr, `TM_ADDR_CTRL);
    assign w_flag = hit_addr(wr, addr, `TM_ADDR_FLAG);
    assign w_cnt_hi = hit_addr(wr, addr, `TM_ADDR_CNT_HI);
    assign w_cnt_lo = hit_addr(wr, addr, `TM_ADDR_CNT_LO);
    assign w_cmp_hi = hit_addr(wr, addr, `TM_ADDR_CMP_HI);
    assign w_cmp_lo = hit_addr(wr, addr, `TM_ADDR_CMP_LO);
    assign w_stop = hit_addr(wr, addr, `TM_ADDR_STOP);
    assign r_flag = hit_addr(rd, addr, `TM_ADDR_FLAG);
    assign r_cnt_hi = hit_addr(rd, addr, `TM_ADDR_CNT_HI);
    assign r_cmp_hi = hit_addr(rd, addr, `TM_ADDR_CMP_HI);

    ////////////////////////////////////////////////////////////////////////////////
    // Compare values are checked against the live counts.
    assign pair = {cnt_hi_ff, cnt_lo_ff};
    assign cmp_pair = {cmp_hi_ff, cmp_lo_ff};
    assign hit_w = wide && tick_lo && (pair == cmp_pair);
    assign hit_h = !wide && tick_hi && (cnt_hi_ff == cmp_hi_ff);
    assign hit_l = !wide && tick_lo && (cnt_lo_ff == cmp_lo_ff);

    // Next counts and the flag events of this cycle.
    always_comb
    begin
        nxt_cnt_hi = cnt_hi_ff;
        nxt_cnt_lo = cnt_lo_ff;
        set_ev = '0;
        if (wide)
        begin
            if (tick_lo)
            begin
                if (hit_w && cfg_ff[2])
                    {nxt_cnt_hi, nxt_cnt_lo} = 16'h0000;
                else
                begin
                    {nxt_cnt_hi, nxt_cnt_lo} = pair + 16'h0001;
                    set_ev[3] = (pair == `TM_PAIR_ONES);
                end
            end
            set_ev[2] = hit_w;
        end
        else
        begin
            if (tick_hi)
            begin
                if (hit_h && cfg_ff[2])
                    nxt_cnt_hi = 8'h00;
                else
                begin
                    nxt_cnt_hi = cnt_hi_ff + 8'h01;
                    set_ev[3] = (cnt_hi_ff == `TM_BYTE_ONES);
                end
            end
            if (tick_lo)
            begin
                if (hit_l && cfg_ff[0])
                    nxt_cnt_lo = 8'h00;
                else
                begin
                    nxt_cnt_lo = cnt_lo_ff + 8'h01;
                    set_ev[1] = (cnt_lo_ff == `TM_BYTE_ONES);
                end
            end
            set_ev[2] = hit_h;
            set_ev[0] = hit_l;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Counters: a CPU write wins over a tick; in 16-bit mode the lower write commits both.
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            cnt_hi_ff <= `TM_CNT_RST;
            cnt_lo_ff <= `TM_CNT_RST;
        end
        else if (wide && w_cnt_lo)
        begin
            cnt_hi_ff <= buf_ff;
            cnt_lo_ff <= wdata;
        end
        else
        begin
            cnt_hi_ff <= (!wide && w_cnt_hi) ? wdata : nxt_cnt_hi;
            cnt_lo_ff <= (!wide && w_cnt_lo) ? wdata : nxt_cnt_lo;
        end
    end

    // Compare registers, with the same buffered pairing in 16-bit mode.
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            cmp_hi_ff <= `TM_CMP_RST;
            cmp_lo_ff <= `TM_CMP_RST;
        end
        else if (wide && w_cmp_lo)
        begin
            cmp_hi_ff <= buf_ff;
            cmp_lo_ff <= wdata;
        end
        else
        begin
            if (!wide && w_cmp_hi)
                cmp_hi_ff <= wdata;
            if (!wide && w_cmp_lo)
                cmp_lo_ff <= wdata;
        end
    end

    // Holding buffer, 16-bit mode only: upper writes park here, upper reads park the lower byte here.
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
            buf_ff <= `TM_CNT_RST;
        else if (wide && (w_cnt_hi || w_cmp_hi))
            buf_ff <= wdata;
        else if (wide && r_cnt_hi)
            buf_ff <= cnt_lo_ff;
        else if (wide && r_cmp_hi)
            buf_ff <= cmp_lo_ff;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Control and clock stop registers.
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            ctrl_ff <= `TM_CTRL_RST;
            stop_ff <= `TM_STOP_RST;
        end
        else
        begin
            if (w_ctrl)
                ctrl_ff <= wdata;
            if (w_stop)
                stop_ff <= wdata | `TM_STOP_FIXED;
        end
    end

    // Enable bits of the flag register.
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
            cfg_ff <= `TM_CFG_RST;
        else if (w_flag)
            cfg_ff <= {wdata[`TM_F_IE_HI], wdata[`TM_F_CLR_HI], wdata[`TM_F_IE_LO],
                       wdata[`TM_F_CLR_LO]};
    end

    // A zero write clears a flag only if it was read as one; a new event wins.
    assign clr_ok = armed_ff & {~wdata[`TM_F_WRAP_HI], ~wdata[`TM_F_HIT_HI],
                                ~wdata[`TM_F_WRAP_LO], ~wdata[`TM_F_HIT_LO]};

    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            flags_ff <= `TM_FLAGS_RST;
            armed_ff <= `TM_FLAGS_RST;
        end
        else
        begin
            flags_ff <= set_ev | (flags_ff & ~({4{w_flag}} & clr_ok));
            if (r_flag)
                armed_ff <= flags_ff;
            else if (w_flag)
                armed_ff <= '0;
        end
    end

    // Interrupt requests: wraps gated by their enables, hits always; acks lose to sets.
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            irq_req_hi <= 1'b0;
            irq_req_lo <= 1'b0;
            cpu_irq_hi <= 1'b0;
            cpu_irq_lo <= 1'b0;
        end
        else
        begin
            irq_req_hi <= (set_ev[3] && cfg_ff[3]) || set_ev[2] ||
                          (irq_req_hi && !irq_ack_hi);
            irq_req_lo <= (set_ev[1] && cfg_ff[1]) || set_ev[0] ||
                          (irq_req_lo && !irq_ack_lo);
            cpu_irq_hi <= irq_req_hi && irq_en_hi;
            cpu_irq_lo <= irq_req_lo && irq_en_lo;
        end
    end

    // Toggle pins: a level write takes effect at once, otherwise each match inverts.
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            toggle_out_hi <= 1'b0;
            toggle_out_lo <= 1'b0;
        end
        else if (w_ctrl)
        begin
            toggle_out_hi <= wdata[`TM_LEVEL_HI];
            toggle_out_lo <= wdata[`TM_LEVEL_LO];
        end
        else
        begin
            if (hit_w || hit_h)
                toggle_out_hi <= !toggle_out_hi;
            if (hit_l)
                toggle_out_lo <= !toggle_out_lo;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read mux; the control register is write-only and reads as zero.
    assign flag_rd = {flags_ff[3], flags_ff[2], cfg_ff[3], cfg_ff[2],
                      flags_ff[1], flags_ff[0], cfg_ff[1], cfg_ff[0]};

    always_comb
    begin
        nxt_rdata = `TM_READ_NONE;
        case (addr)
            `TM_ADDR_FLAG: nxt_rdata = flag_rd;
            `TM_ADDR_CNT_HI: nxt_rdata = cnt_hi_ff;
            `TM_ADDR_CNT_LO: nxt_rdata = wide ? buf_ff : cnt_lo_ff;
            `TM_ADDR_CMP_HI: nxt_rdata = cmp_hi_ff;
            `TM_ADDR_CMP_LO: nxt_rdata = wide ? buf_ff : cmp_lo_ff;
            `TM_ADDR_STOP: nxt_rdata = stop_ff;
            default: nxt_rdata = `TM_READ_NONE;
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (!nrst)
            rdata <= `TM_READ_NONE;
        else if (rd)
            rdata <= nxt_rdata;
        else
            rdata <= `TM_READ_NONE;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks of the counting, flag and pin behaviour.
    sequence s_upper_parked;
        wide && w_cnt_hi ##1 wide && w_cnt_lo && !w_cnt_hi;
    endsequence

    a_pair_commit: assert property (@(posedge core_clk) disable iff (!nrst)
        s_upper_parked |=> (cnt_hi_ff == $past(wdata, 2)) && (cnt_lo_ff == $past(wdata)))
        else $error("buffered counter write did not commit both bytes");

    a_wide_cascade: assert property (@(posedge core_clk) disable iff (!nrst)
        wide && tick_lo && !hit_w && cnt_lo_ff == `TM_BYTE_ONES && !wr
        |=> cnt_lo_ff == 8'h00 && cnt_hi_ff == $past(cnt_hi_ff) + 8'h01)
        else $error("upper half did not advance on lower wrap");

    a_wrap_flag: assert property (@(posedge core_clk) disable iff (!nrst)
        !wide && tick_lo && cnt_lo_ff == `TM_BYTE_ONES && !(hit_l && cfg_ff[0])
        |=> flags_ff[1] && (irq_req_lo == ($past(cfg_ff[1]) ||
            ($past(irq_req_lo) && !$past(irq_ack_lo)) || $past(hit_l))))
        else $error("lower wrap flag or gated request wrong");

    a_hit_clear: assert property (@(posedge core_clk) disable iff (!nrst)
        hit_l && cfg_ff[0] && !wr |=> cnt_lo_ff == 8'h00 && flags_ff[0] && irq_req_lo)
        else $error("lower match did not clear or flag");

    a_wide_hit: assert property (@(posedge core_clk) disable iff (!nrst)
        hit_w |=> flags_ff[2] && irq_req_hi ##1 (cpu_irq_hi == $past(irq_en_hi)))
        else $error("16-bit match did not raise flag and request");

    a_level_write: assert property (@(posedge core_clk) disable iff (!nrst)
        w_ctrl |=> toggle_out_hi == $past(wdata[`TM_LEVEL_HI]) &&
                   toggle_out_lo == $past(wdata[`TM_LEVEL_LO]))
        else $error("toggle level write not applied");

    a_toggle_hit: assert property (@(posedge core_clk) disable iff (!nrst)
        hit_l && !w_ctrl |=> toggle_out_lo != $past(toggle_out_lo))
        else $error("lower match did not invert pin");

    a_clear_guard: assert property (@(posedge core_clk) disable iff (!nrst)
        w_flag |=> &(flags_ff | ~$past(flags_ff) | $past(armed_ff)))
        else $error("flag cleared without prior read");

    a_standby_halt: assert property (@(posedge core_clk) disable iff (!nrst)
        (standby && !wr) [*2] |=> $stable(cnt_hi_ff) && $stable(cnt_lo_ff))
        else $error("counters moved in module standby");

    a_no_event_hi: assert property (@(posedge core_clk) disable iff (!nrst)
        !wide && !wr && tk.evt && !(tk.div32 || tk.div16 || tk.div4 || tk.wdiv4)
        |=> $stable(cnt_hi_ff)) else $error("upper counter moved on an event tick");
endmodule

/* File: logic/dual_timer_map.svh */
// Register addresses, field positions, reset values and divider counts of the timer.
// Assumes it is included by its bare name from the timer design files.
`ifndef DUAL_TIMER_MAP_SVH
`define DUAL_TIMER_MAP_SVH

`define TM_ADDR_CTRL 16'hFFB6
`define TM_ADDR_FLAG 16'hFFB7
`define TM_ADDR_CNT_HI 16'hFFB8
`define TM_ADDR_CNT_LO 16'hFFB9
`define TM_ADDR_CMP_HI 16'hFFBA
`define TM_ADDR_CMP_LO 16'hFFBB
`define TM_ADDR_STOP 16'hFFFA

`define TM_CNT_RST 8'h00
`define TM_CMP_RST 8'hFF
`define TM_CTRL_RST 8'h00
`define TM_FLAGS_RST 4'h0
`define TM_CFG_RST 4'h0
`define TM_STOP_RST 8'hFF
`define TM_STOP_FIXED 8'hC0
`define TM_BYTE_ONES 8'hFF
`define TM_PAIR_ONES 16'hFFFF
`define TM_READ_NONE 8'h00

`define TM_LEVEL_HI 7
`define TM_WIDTH_SEL 6
`define TM_SRC_HI_MSB 6
`define TM_SRC_HI_LSB 4
`define TM_LEVEL_LO 3
`define TM_SRC_LO_MSB 2
`define TM_SRC_LO_LSB 0
`define TM_STOP_BIT 1

`define TM_F_WRAP_HI 7
`define TM_F_HIT_HI 6
`define TM_F_IE_HI 5
`define TM_F_CLR_HI 4
`define TM_F_WRAP_LO 3
`define TM_F_HIT_LO 2
`define TM_F_IE_LO 1
`define TM_F_CLR_LO 0

`define TM_DIV32_END 5'h1F
`define TM_DIV16_END 4'hF
`define TM_DIV4_END 2'h3

`endif

/* File: logic/dual_timer_pkg.sv */
// Types shared by the timer design files.
// Assumes nothing beyond a SystemVerilog compiler.
package dual_timer_pkg;

    typedef logic [7:0] byte_t;

    // Count clock selections of one counter half.
    typedef enum logic [2:0]
    {
        SRC_EVENT = 3'h0,
        SRC_DIV32 = 3'h4,
        SRC_DIV16 = 3'h5,
        SRC_DIV4 = 3'h6,
        SRC_WDIV4 = 3'h7
    } clk_src_e;

endpackage

/* File: logic/tick_if.sv */
// Count tick bundle passed from the prescaler to the timer core.
// Assumes both ends run on the same core clock.
`timescale 1ns/1ps
interface tick_if;
    logic div32;
    logic div16;
    logic div4;
    logic wdiv4;
    logic evt;

    modport src (output div32, output div16, output div4, output wdiv4, output evt);
    modport snk (input div32, input div16, input div4, input wdiv4, input evt);
endinterface

/* File: logic/tick_prescaler.sv */
// Prescaler: makes one-cycle count ticks from the core clock, the watch clock and events.
// Assumes watch_clk and event_in are sampled as synchronous inputs of core_clk.
`timescale 1ns/1ps
`include "dual_timer_map.svh"
module tick_prescaler
(
    input wire logic core_clk, // Core clock.
    input wire logic nrst, // Synchronous reset, active low.
    input wire logic run_main, // Core-derived ticks allowed.
    input wire logic run_watch, // Watch tick allowed; the event tick is gated by run_main.
    input wire logic watch_clk, // Watch clock level.
    input wire logic event_in, // External event level.
    input wire logic event_fall, // Count falling event edges when high.
    tick_if.src tk // Tick outputs.
);
    logic [4:0] div_ff;
    logic [1:0] wdiv_ff;
    logic watch_ff;
    logic event_ff;
    logic watch_rise;
    logic evt_edge;

    ////////////////////////////////////////////////////////////////////////////////
    // Free divider of the core clock, held at zero while the main ticks are not allowed.
    always_ff @(posedge core_clk)
    begin
        if (!nrst || !run_main)
            div_ff <= '0;
        else
            div_ff <= div_ff + 5'h01;
    end

    // Edge memory of the watch clock and the event pin, plus the watch quarter counter.
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            watch_ff <= 1'b0;
            event_ff <= 1'b0;
            wdiv_ff <= '0;
        end
        else
        begin
            watch_ff <= watch_clk;
            event_ff <= event_in;
            if (watch_rise)
                wdiv_ff <= wdiv_ff + 2'h1;
        end
    end

    assign watch_rise = run_watch && watch_clk && !watch_ff;
    assign evt_edge = event_fall ? (event_ff && !event_in) : (!event_ff && event_in);

    // Ticks last exactly one core cycle.
    assign tk.div32 = run_main && (div_ff == `TM_DIV32_END);
    assign tk.div16 = run_main && (div_ff[3:0] == `TM_DIV16_END);
    assign tk.div4 = run_main && (div_ff[1:0] == `TM_DIV4_END);
    assign tk.wdiv4 = watch_rise && (wdiv_ff == `TM_DIV4_END);
    assign tk.evt = run_main && evt_edge;
endmodule

/* File: test/event_partner.sv */
// Partner model: external event source, free watch clock and toggle pin loads.
// Assumes the bench calls send_edges right after a rising core clock edge.
`timescale 1ns/1ps
module event_partner
(
    input wire logic core_clk, // Core clock.
    output logic event_in, // Event level to the timer.
    output logic watch_clk, // Free-running watch clock.
    input wire logic toggle_out_hi, // Upper toggle pin load.
    input wire logic toggle_out_lo // Lower toggle pin load.
);
    logic [2:0] w_cnt = 3'h0;
    initial event_in = 1'b0;
    ////////////////////////////////////////////////////////////////////////////////
    // The watch clock runs free at one eighth of the core rate.
    always @(posedge core_clk)
    begin
        w_cnt <= w_cnt + 3'h1;
    end
    assign watch_clk = w_cnt[2];
    // Each rising edge is held two cycles high and two low; in 8-bit mode it reaches only the lower counter.
    task automatic send_edges(input int n);
        repeat (n)
        begin
            event_in <= 1'b1;
            repeat (2) @(posedge core_clk);
            event_in <= 1'b0;
            repeat (2) @(posedge core_clk);
        end
    endtask
endmodule

/* File: test/test_dual_mode_compare_timer.sv */
// Testbench of the compare timer: register access, event counting, flags and toggle pins.
// Assumes the design files and the event partner model are compiled first.
`timescale 1ns/1ps
`include "dual_timer_map.svh"
module test_dual_mode_compare_timer;
    logic core_clk, nrst, wr, rd, rd_d, irq_en_hi, irq_en_lo, irq_ack_hi, irq_ack_lo;
    logic event_in, watch_clk, irq_req_hi, irq_req_lo, cpu_irq_hi, cpu_irq_lo;
    logic toggle_out_hi, toggle_out_lo, event_fall, low_power;
    logic [15:0] addr, v;
    logic [7:0] wdata, rdata;
    logic [7:0] exp_q[$];
    logic [15:0] rst_a[8] = '{16'hFFB6, 16'hFFB7, 16'hFFB8, 16'hFFB9, 16'hFFBA, 16'hFFBB,
        16'hFFFA, 16'hFFBC};
    logic [7:0] rst_d[8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'h00};
    int n_mismatch = 0;
    int comparisons = 0;
    ////////////////////////////////////////////////////////////////////////////////
    dual_mode_compare_timer i_dual_mode_compare_timer
    (
        .core_clk(core_clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .event_in(event_in), .event_fall(event_fall), .watch_clk(watch_clk),
        .low_power(low_power), .irq_en_hi(irq_en_hi), .irq_en_lo(irq_en_lo),
        .irq_ack_hi(irq_ack_hi), .irq_ack_lo(irq_ack_lo), .irq_req_hi(irq_req_hi),
        .irq_req_lo(irq_req_lo), .cpu_irq_hi(cpu_irq_hi), .cpu_irq_lo(cpu_irq_lo),
        .toggle_out_hi(toggle_out_hi), .toggle_out_lo(toggle_out_lo)
    );
    event_partner i_event_partner
    (
        .core_clk(core_clk), .event_in(event_in), .watch_clk(watch_clk),
        .toggle_out_hi(toggle_out_hi), .toggle_out_lo(toggle_out_lo)
    );
    // The clock toggles every half period of 5 ns.
    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge core_clk);
        wr <= 1'b0;
        @(posedge core_clk);
    endtask
    // A lone upper write only fills the holding byte; the lower write commits both.
    task automatic wr16(input logic [15:0] a, input logic [15:0] d);
        addr <= a;
        wdata <= d[15:8];
        wr <= 1'b1;
        @(posedge core_clk);
        addr <= a + 16'h1;
        wdata <= d[7:0];
        @(posedge core_clk);
        wr <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic rd_exp(input logic [15:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        addr <= a;
        rd <= 1'b1;
        @(posedge core_clk);
        rd <= 1'b0;
        @(posedge core_clk);
    endtask
    // Waits a bounded time for a request flag, then one more cycle for the CPU line.
    task automatic wait_req(input bit hi);
        int i;
        for (i = 0; i < 300 && (hi ? irq_req_hi : irq_req_lo) !== 1'b1; i++)
            @(posedge core_clk);
        if (i == 300)
        begin
            n_mismatch++;
            wrap_up();
        end
        else
            @(posedge core_clk);
    endtask
    task automatic ack(input bit hi);
        irq_ack_hi <= hi;
        irq_ack_lo <= !hi;
        @(posedge core_clk);
        irq_ack_hi <= 1'b0;
        irq_ack_lo <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic wrap_up();
        if (n_mismatch == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Read data stands in the cycle after the strobe; the oldest note is compared then.
    always @(posedge core_clk)
    begin
        if (rd_d === 1'b1)
            check(rdata, exp_q.pop_front());
        rd_d = rd;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence: reset values, buffered access, 8-bit events, pins, 16-bit events.
    initial
    begin
        nrst = 1'b0;
        {wr, rd, rd_d, irq_ack_hi, irq_ack_lo, event_fall, low_power} = 7'h00;
        {addr, wdata, irq_en_hi, irq_en_lo} = {24'h000000, 2'h3};
        void'($urandom(32'hE6CB5983));
        repeat (2) @(posedge core_clk);
        nrst <= 1'b1;
        @(posedge core_clk);
        foreach (rst_a[k]) rd_exp(rst_a[k], rst_d[k]);
        wr_reg(`TM_ADDR_STOP, 8'hFD);
        rd_exp(`TM_ADDR_STOP, 8'hFD);
        repeat (3)
        begin
            v = 16'($urandom);
            wr16(`TM_ADDR_CNT_HI, v);
            wr16(`TM_ADDR_CMP_HI, ~v);
            rd_exp(`TM_ADDR_CNT_HI, v[15:8]);
            rd_exp(`TM_ADDR_CNT_LO, v[7:0]);
            rd_exp(`TM_ADDR_CMP_HI, ~v[15:8]);
            rd_exp(`TM_ADDR_CMP_LO, ~v[7:0]);
        end
        wr_reg(`TM_ADDR_CNT_HI, 8'hA5);
        rd_exp(`TM_ADDR_CNT_HI, v[15:8]);
        wr16(`TM_ADDR_CNT_HI, 16'h0000);
        wr16(`TM_ADDR_CMP_HI, 16'hFFFF);
        wr_reg(`TM_ADDR_STOP, 8'hFF);
        wr_reg(`TM_ADDR_CTRL, 8'h40);
        wr_reg(`TM_ADDR_CNT_LO, 8'h00);
        wr_reg(`TM_ADDR_CMP_LO, 8'h03);
        wr_reg(`TM_ADDR_FLAG, 8'h0F);
        rd_exp(`TM_ADDR_FLAG, 8'h03);
        i_event_partner.send_edges(4);
        wait_req(1'b0);
        check({7'h0, cpu_irq_lo}, 8'h01);
        check({7'h0, toggle_out_lo}, 8'h01);
        rd_exp(`TM_ADDR_CNT_LO, 8'h00);
        wr_reg(`TM_ADDR_FLAG, 8'h03);
        rd_exp(`TM_ADDR_FLAG, 8'h07);
        wr_reg(`TM_ADDR_FLAG, 8'h03);
        rd_exp(`TM_ADDR_FLAG, 8'h03);
        ack(1'b0);
        check({7'h0, irq_req_lo}, 8'h00);
        irq_en_lo <= 1'b0;
        wr_reg(`TM_ADDR_CNT_LO, 8'hFF);
        i_event_partner.send_edges(1);
        wait_req(1'b0);
        check({7'h0, cpu_irq_lo}, 8'h00);
        rd_exp(`TM_ADDR_FLAG, 8'h0B);
        rd_exp(`TM_ADDR_CNT_LO, 8'h00);
        wr_reg(`TM_ADDR_CTRL, 8'hC8);
        check({6'h0, toggle_out_hi, toggle_out_lo}, 8'h03);
        rd_exp(`TM_ADDR_CTRL, 8'h00);
        low_power <= 1'b1;
        wr_reg(`TM_ADDR_CTRL, 8'h4E);
        repeat (8) @(posedge core_clk);
        rd_exp(`TM_ADDR_CNT_LO, 8'h00);
        low_power <= 1'b0;
        wr_reg(`TM_ADDR_CTRL, 8'h00);
        check({6'h0, toggle_out_hi, toggle_out_lo}, 8'h00);
        wr_reg(`TM_ADDR_FLAG, 8'h30);
        wr16(`TM_ADDR_CMP_HI, 16'h0001);
        wr16(`TM_ADDR_CNT_HI, 16'hFFFF);
        i_event_partner.send_edges(1);
        wait_req(1'b1);
        rd_exp(`TM_ADDR_FLAG, 8'hB0);
        ack(1'b1);
        event_fall <= 1'b1;
        i_event_partner.send_edges(2);
        wait_req(1'b1);
        check({7'h0, cpu_irq_hi}, 8'h01);
        check({7'h0, toggle_out_hi}, 8'h01);
        rd_exp(`TM_ADDR_FLAG, 8'hF0);
        rd_exp(`TM_ADDR_CNT_HI, 8'h00);
        rd_exp(`TM_ADDR_CNT_LO, 8'h00);
        @(posedge core_clk);
        wrap_up();
    end
endmodule
